/* File: rclp_ctrl.sv */
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`default_nettype none
// How it works
// RULE_01 - outside reset source holds reset pin low at least 20 oscillator cycles
// RULE_02 - pin release with stable clock ends reset and starts vector fetch
// RULE_03 - usb block reset comes from hardware reset only
// RULE_04 - while reset pin low all ports are floating inputs
// RULE_05 - writing one to mode register 0 bit 3 causes software reset
// RULE_06 - software reset leaves internal ram untouched
// RULE_07 - after any reset cpu clock is main clock divided by eight
// RULE_08 - main clock stop bit halts main clock
// RULE_09 - oscillator drive select forced to one on reset and stop entry
// RULE_10 - cpu clock divides main clock by 1, 2, 4, 8 or 16
// RULE_11 - divide-by-8 when high select set and stop bit clear, else fine pair
// RULE_12 - stop entry sets the divide-by-eight select bit
// RULE_13 - peripheral clocks are main clock undivided, by 8 and by 32
// RULE_14 - peripheral clocks stop with main clock or wait with stop bit
// RULE_15 - converter clock runs at main clock rate
// RULE_16 - clock output pin carries f8 or f32 per two select bits
// RULE_17 - in wait, clock output toggles unless wait stop bit set
// RULE_18 - all-clock stop bit stops oscillation and enters stop mode
// RULE_19 - external event timer and external clock serial still work in stop
// RULE_20 - stop exits on hardware reset or interrupt enabled before entry
// RULE_21 - ports and clock output hold their state in low-power modes; clock output still toggles in wait unless wait stop bit set
// RULE_22 - wait stops cpu clock and watchdog, oscillator keeps running
// RULE_23 - wait wake-up resumes with the same cpu divider
// RULE_24 - software leaves divide-by-8 only after oscillation stabilises
// RULE_25 - clock register writes take effect only when protect bit 0 set
// RULE_26 - divider changes apply only at a common clock boundary
// RULE_27 - reset pin is synchronised before releasing internal reset
module rclp_ctrl
  import rclp_pkg::*;
#(
  parameter int NIRQ = 8
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            reset_pin_n,
  input  wire logic            osc_stable,
  input  wire logic            wait_exec,
  input  wire logic [NIRQ-1:0] irq_req,
  input  wire logic [NIRQ-1:0] irq_enabled,
  output logic                 core_reset,
  output logic                 usb_reset,
  output logic                 ram_init,
  output logic                 vector_fetch,
  output logic                 ports_float,
  output logic                 port_hold,
  output logic                 osc_enable,
  output logic                 oscillator_output_drive,
  output logic                 cpu_clk_en,
  output logic                 watchdog_run,
  output logic                 periph_clock_undivided,
  output logic                 periph_clock_div_eight,
  output logic                 periph_clock_div_thirtytwo,
  output logic                 converter_clock,
  output logic                 ext_clock_units_run,
  output logic                 clock_output_pin,
  output logic                 clock_output_pin_oe
);

  // ==========================================================
  // reset pin synchroniser and reset distribution
  logic pin_s1_r;
  logic pin_s2_r;
  logic sw_req_r;
  logic core_reset_r;
  logic usb_reset_r;
  logic ram_init_r;
  logic vector_fetch_r;
  logic ports_float_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= reset_pin_n;
      pin_s2_r <= pin_s1_r; // [RULE_27]
    end
  end

  wire hw_rst_w   = !pin_s2_r;
  // a software reset clears the same control state as a pin reset
  wire core_rst_w = hw_rst_w | sw_req_r; // [RULE_05]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_reset_r   <= 1'b1;
      usb_reset_r    <= 1'b1;
      ram_init_r     <= 1'b1;
      ports_float_r  <= 1'b1;
      vector_fetch_r <= 1'b0;
    end else begin
      core_reset_r   <= core_rst_w;
      usb_reset_r    <= hw_rst_w; // [RULE_03]
      ram_init_r     <= hw_rst_w; // [RULE_06]
      ports_float_r  <= hw_rst_w; // [RULE_04]
      vector_fetch_r <= core_reset_r && !core_rst_w && osc_stable; // [RULE_02]
    end
  end

  // ==========================================================
  // control registers
  logic [7:0]      scc0_r;
  logic [7:0]      scc1_r;
  logic [1:0]      prot_r;
  logic [NIRQ-1:0] irq_snap_r;
  rclp_pwr_t       pwr_r;
  rclp_pwr_t       pwr_nxt;

  // ==========================================================
  // axi4-lite slave
  logic [7:0]  aw_addr_r;
  logic        aw_full_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_full_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  wire aw_take  = s_axi_awvalid && !aw_full_r && !bvalid_r;
  wire w_take   = s_axi_wvalid && !w_full_r && !bvalid_r;
  wire wr_fire  = aw_full_r && w_full_r && !bvalid_r;
  wire [5:0] wr_idx = aw_addr_r[7:2];
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire wr_mode0 = wr_fire && wr_idx == RCLP_IDX_MODE0[5:0];
  wire wr_scc0  = wr_fire && wr_idx == RCLP_IDX_SCC0[5:0];
  wire wr_scc1  = wr_fire && wr_idx == RCLP_IDX_SCC1[5:0];
  wire wr_prot  = wr_fire && wr_idx == RCLP_IDX_PROT[5:0];
  wire wr_stat  = wr_fire && wr_idx == RCLP_IDX_STAT[5:0];
  wire wr_known = wr_mode0 | wr_scc0 | wr_scc1 | wr_prot | wr_stat;
  wire lane0    = w_strb_r[0];
  // protect bits gate the stores, not the bus handshake
  wire scc0_we  = wr_scc0 && lane0 && prot_r[RCLP_PROT_CLK]; // [RULE_25]
  wire scc1_we  = wr_scc1 && lane0 && prot_r[RCLP_PROT_CLK]; // [RULE_25]
  wire mode0_we = wr_mode0 && lane0 && prot_r[RCLP_PROT_MODE];
  wire sw_hit   = mode0_we && w_data_r[RCLP_MODE0_SWRST]; // [RULE_05]
  wire ar_take  = s_axi_arvalid && !rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= 8'h00;
      aw_full_r <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      w_full_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RCLP_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_known ? RCLP_RESP_OKAY : RCLP_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  wire [3:0] div_act_w;
  wire [31:0] stat_w = {24'h00_0000, div_act_w, 1'b0, pwr_r};
  wire [31:0] rd_mux_w =
    (rd_idx == RCLP_IDX_MODE0[5:0]) ? 32'h0000_0000 :
    (rd_idx == RCLP_IDX_SCC0[5:0])  ? {24'h00_0000, scc0_r} :
    (rd_idx == RCLP_IDX_SCC1[5:0])  ? {24'h00_0000, scc1_r} :
    (rd_idx == RCLP_IDX_PROT[5:0])  ? {30'h0000_0000, prot_r} :
    (rd_idx == RCLP_IDX_STAT[5:0])  ? stat_w : 32'h0000_0000;
  wire rd_known = rd_idx == RCLP_IDX_MODE0[5:0] || rd_idx == RCLP_IDX_SCC0[5:0] ||
                  rd_idx == RCLP_IDX_SCC1[5:0] || rd_idx == RCLP_IDX_PROT[5:0] ||
                  rd_idx == RCLP_IDX_STAT[5:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RCLP_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux_w;
      rresp_r  <= rd_known ? RCLP_RESP_OKAY : RCLP_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_req_r <= 1'b0;
    end else begin
      sw_req_r <= sw_hit;
    end
  end

  // ==========================================================
  // power state and clock control bits
  wire stop_req  = scc1_we && w_data_r[RCLP_SCC1_ALLSTOP]; // [RULE_18]
  wire wake_stop = |(irq_req & irq_snap_r); // [RULE_20]
  wire wake_wait = |(irq_req & irq_enabled);

  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      RCLP_RUN: begin
        if (stop_req) begin
          pwr_nxt = RCLP_STOP;
        end else if (wait_exec) begin
          pwr_nxt = RCLP_WAIT;
        end
      end
      RCLP_WAIT: begin
        if (wake_wait) begin
          pwr_nxt = RCLP_RUN;
        end
      end
      RCLP_STOP: begin
        if (wake_stop) begin
          pwr_nxt = RCLP_RUN;
        end
      end
      default: pwr_nxt = RCLP_RUN;
    endcase
  end

  wire entering_stop = pwr_r == RCLP_RUN && pwr_nxt == RCLP_STOP;

  always_ff @(posedge aclk) begin
    if (!aresetn || core_rst_w) begin
      pwr_r      <= RCLP_RUN; // [RULE_20]
      scc0_r     <= RCLP_SCC0_RST; // [RULE_07]
      scc1_r     <= RCLP_SCC1_RST; // [RULE_09]
      prot_r     <= RCLP_PROT_RST;
      irq_snap_r <= '0;
    end else begin
      pwr_r <= pwr_nxt;
      if (wr_prot && lane0) begin
        prot_r <= w_data_r[1:0];
      end
      if (entering_stop) begin
        irq_snap_r <= irq_enabled; // [RULE_20]
        scc0_r     <= scc0_r | (8'h01 << RCLP_SCC0_DIV8); // [RULE_12]
        scc1_r     <= w_data_r[7:0] | (8'h01 << RCLP_SCC1_DRIVE); // [RULE_09]
      end else begin
        if (scc0_we) begin
          scc0_r <= w_data_r[7:0];
        end
        if (scc1_we) begin
          scc1_r <= w_data_r[7:0];
        end
        if (pwr_r == RCLP_STOP && wake_stop) begin
          scc1_r[RCLP_SCC1_ALLSTOP] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // dividers
  logic [4:0] cnt_r;
  logic [3:0] div_act_r;
  logic       cpu_en_r;
  logic       p1_r;
  logic       p8_r;
  logic       p32_r;
  logic       conv_r;
  logic       osc_en_r;
  logic       wdt_r;
  logic       hold_r;
  logic       ext_r;
  logic       clock_output_pin_r;
  logic       clock_output_pin_oe_r;

  wire osc_run  = !scc0_r[RCLP_SCC0_OSCSTOP] && pwr_r != RCLP_STOP; // [RULE_08] [RULE_18]
  wire in_wait  = pwr_r == RCLP_WAIT;
  wire per_run  = osc_run && !(in_wait && scc0_r[RCLP_SCC0_WAITSTOP]); // [RULE_14]
  wire [1:0] fine_w = {scc1_r[RCLP_SCC1_FINE_HI], scc1_r[RCLP_SCC1_FINE_LO]};
  wire div8_w   = scc0_r[RCLP_SCC0_DIV8] && !scc0_r[RCLP_SCC0_OSCSTOP]; // [RULE_11]
  wire [3:0] div_req_w = div8_w          ? RCLP_DIV8 :
                         (fine_w == 2'h0) ? RCLP_DIV1 :
                         (fine_w == 2'h1) ? RCLP_DIV2 :
                         (fine_w == 2'h2) ? RCLP_DIV4 : RCLP_DIV16; // [RULE_10] [RULE_11]
  // swap only when every divider is at its last phase, so no short pulse
  wire boundary = cnt_r[3:0] == 4'hF; // [RULE_26]
  wire cpu_hit  = (cnt_r[3:0] & div_act_r) == div_act_r;
  wire [1:0] osel_w = scc0_r[RCLP_SCC0_OUTSEL_LO +: 2];
  wire out_on   = osel_w == RCLP_OUT_F8 || osel_w == RCLP_OUT_F32; // [RULE_16]
  wire out_tgl  = (osel_w == RCLP_OUT_F8) ? cnt_r[1:0] == 2'h3 : cnt_r[3:0] == 4'hF;
  assign div_act_w = div_act_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || core_rst_w) begin
      cnt_r     <= 5'h00;
      div_act_r <= RCLP_DIV8; // [RULE_07]
    end else begin
      if (osc_run) begin
        cnt_r <= cnt_r + 5'h01;
      end
      // divider is frozen in wait, so wake-up keeps the old rate
      if (osc_run && boundary && !in_wait) begin
        div_act_r <= div_req_w; // [RULE_26] [RULE_23]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || core_rst_w) begin
      cpu_en_r    <= 1'b0;
      p1_r        <= 1'b0;
      p8_r        <= 1'b0;
      p32_r       <= 1'b0;
      conv_r      <= 1'b0;
      osc_en_r    <= 1'b1;
      wdt_r       <= 1'b0;
      hold_r      <= 1'b0;
      ext_r       <= 1'b0;
      clock_output_pin_r    <= 1'b0;
      clock_output_pin_oe_r <= 1'b0;
    end else begin
      cpu_en_r    <= osc_run && !in_wait && cpu_hit; // [RULE_22]
      p1_r        <= per_run; // [RULE_13]
      p8_r        <= per_run && cnt_r[2:0] == 3'h7; // [RULE_13]
      p32_r       <= per_run && cnt_r == 5'h1F; // [RULE_13]
      conv_r      <= osc_run; // [RULE_15]
      osc_en_r    <= osc_run; // [RULE_22]
      wdt_r       <= osc_run && !in_wait; // [RULE_22]
      hold_r      <= pwr_r != RCLP_RUN; // [RULE_21]
      ext_r       <= 1'b1; // [RULE_19]
      clock_output_pin_oe_r <= out_on;
      if (!out_on) begin
        clock_output_pin_r <= 1'b0;
      end else if (per_run && out_tgl) begin
        clock_output_pin_r <= !clock_output_pin_r; // [RULE_17] [RULE_21]
      end
    end
  end

  assign s_axi_awready              = aw_take;
  assign s_axi_wready               = w_take;
  assign s_axi_bvalid               = bvalid_r;
  assign s_axi_bresp                = bresp_r;
  assign s_axi_arready              = ar_take;
  assign s_axi_rvalid               = rvalid_r;
  assign s_axi_rdata                = rdata_r;
  assign s_axi_rresp                = rresp_r;
  assign core_reset                 = core_reset_r;
  assign usb_reset                  = usb_reset_r;
  assign ram_init                   = ram_init_r;
  assign vector_fetch               = vector_fetch_r;
  assign ports_float                = ports_float_r;
  assign port_hold                  = hold_r;
  assign osc_enable                 = osc_en_r;
  assign oscillator_output_drive    = scc1_r[RCLP_SCC1_DRIVE];
  assign cpu_clk_en                 = cpu_en_r;
  assign watchdog_run               = wdt_r;
  assign periph_clock_undivided     = p1_r;
  assign periph_clock_div_eight     = p8_r;
  assign periph_clock_div_thirtytwo = p32_r;
  assign converter_clock            = conv_r;
  assign ext_clock_units_run        = ext_r;
  assign clock_output_pin           = clock_output_pin_r;
  assign clock_output_pin_oe        = clock_output_pin_oe_r;

  // ==========================================================
  // assertions
  a_usb_sw_isolate: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
    sw_hit && pin_s2_r ##1 pin_s2_r |=> !usb_reset)
    else $error("usb reset followed a software reset");
  a_ports_float: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
    !pin_s2_r |=> ports_float)
    else $error("ports not floating during pin reset");
  a_sw_reset: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
    sw_hit |=> ##1 core_reset && !ram_init)
    else $error("software reset missing or touched ram");
  a_reset_div8: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
    core_rst_w |=> div_act_r == RCLP_DIV8 && scc1_r[RCLP_SCC1_DRIVE])
    else $error("reset did not restore divide by eight");
  a_stop_bits: assert property (@(posedge aclk) disable iff (!aresetn || core_rst_w) // [RULE_12]
    entering_stop |=> pwr_r == RCLP_STOP && scc0_r[RCLP_SCC0_DIV8] && scc1_r[RCLP_SCC1_DRIVE])
    else $error("stop entry did not set divider and drive bits");
  a_stop_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_18]
    pwr_r == RCLP_STOP && !core_rst_w |=> !cpu_clk_en && !periph_clock_undivided && !converter_clock)
    else $error("clock pulse while stopped");
  a_p32_period: assert property (@(posedge aclk) disable iff (!aresetn || core_rst_w) // [RULE_13]
    periph_clock_div_thirtytwo |-> ##1 !periph_clock_div_thirtytwo [*8])
    else $error("f32 pulses too close");
  a_wait_cpu_off: assert property (@(posedge aclk) disable iff (!aresetn || core_rst_w) // [RULE_22]
    in_wait ##1 in_wait |-> !cpu_clk_en && !watchdog_run && osc_enable)
    else $error("cpu or watchdog ran in wait");
  a_protect_gate: assert property (@(posedge aclk) disable iff (!aresetn || core_rst_w) // [RULE_25]
    (wr_scc0 || wr_scc1) && !prot_r[RCLP_PROT_CLK] |=> $stable(scc0_r) && $stable(scc1_r))
    else $error("protected clock register changed");
  a_div_boundary: assert property (@(posedge aclk) disable iff (!aresetn || core_rst_w) // [RULE_26]
    !$stable(div_act_r) |-> $past(cnt_r[3:0]) == 4'hF || $past(core_rst_w))
    else $error("divider switched off boundary");
  a_wait_clock_output_pin: assert property (@(posedge aclk) disable iff (!aresetn || core_rst_w) // [RULE_17]
    in_wait && scc0_r[RCLP_SCC0_WAITSTOP] ##1 in_wait |=> $stable(clock_output_pin))
    else $error("clock output moved in wait with stop bit");
  c_stop_wake: cover property (@(posedge aclk) disable iff (!aresetn)
    pwr_r == RCLP_STOP ##1 pwr_r == RCLP_RUN);
  c_wait_wake: cover property (@(posedge aclk) disable iff (!aresetn)
    pwr_r == RCLP_WAIT ##1 pwr_r == RCLP_RUN);
  c_div_change: cover property (@(posedge aclk) disable iff (!aresetn)
    div_act_r == RCLP_DIV8 ##1 div_act_r == RCLP_DIV2);
  c_sw_reset: cover property (@(posedge aclk) disable iff (!aresetn) sw_hit);

endmodule : rclp_ctrl
`default_nettype wire

/* File: rclp_ext_model.sv */
`default_nettype none
// ==========================================================
// outside reset circuit and main oscillator
module rclp_ext_model #(
  parameter int LOW_CYC = 24
) (
  input  wire logic aclk,
  input  wire logic pin_req,
  output var  logic reset_pin_n,
  output var  logic osc_stable
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int up  = 0;
  initial begin
    reset_pin_n = 1'b1;
    osc_stable  = 1'b0;
  end
  // oscillator needs a while to settle, software must wait for it
  always @(posedge aclk) begin
    if (up < 40) up <= up + 1;
    else osc_stable <= 1'b1;
  end
  // pin held low longer than the minimum, then released
  always @(posedge aclk) begin
    if (pin_req) begin
      cnt         <= LOW_CYC;
      reset_pin_n <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) reset_pin_n <= 1'b1;
    end
  end
endmodule : rclp_ext_model
`default_nettype wire

/* File: rclp_pkg.sv */
`default_nettype none
package rclp_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] RCLP_IDX_MODE0  = 8'h04;
  localparam logic [7:0] RCLP_IDX_SCC0   = 8'h06;
  localparam logic [7:0] RCLP_IDX_SCC1   = 8'h07;
  localparam logic [7:0] RCLP_IDX_PROT   = 8'h0A;
  localparam logic [7:0] RCLP_IDX_STAT   = 8'h0B;
  // ==========================================================
  // field positions
  localparam int RCLP_MODE0_SWRST    = 3;
  localparam int RCLP_SCC0_OUTSEL_LO = 0;
  localparam int RCLP_SCC0_WAITSTOP  = 2;
  localparam int RCLP_SCC0_OSCSTOP   = 5;
  localparam int RCLP_SCC0_DIV8      = 6;
  localparam int RCLP_SCC1_ALLSTOP   = 0;
  localparam int RCLP_SCC1_DRIVE     = 5;
  localparam int RCLP_SCC1_FINE_LO   = 6;
  localparam int RCLP_SCC1_FINE_HI   = 7;
  localparam int RCLP_PROT_CLK       = 0;
  localparam int RCLP_PROT_MODE      = 1;
  // ==========================================================
  // values after reset
  localparam logic [7:0] RCLP_SCC0_RST  = 8'h40;
  localparam logic [7:0] RCLP_SCC1_RST  = 8'h20;
  localparam logic [7:0] RCLP_MODE0_RST = 8'h00;
  localparam logic [1:0] RCLP_PROT_RST  = 2'h0;
  // ==========================================================
  // divider masks: cpu tick when (count & mask) == mask
  localparam logic [3:0] RCLP_DIV1  = 4'h0;
  localparam logic [3:0] RCLP_DIV2  = 4'h1;
  localparam logic [3:0] RCLP_DIV4  = 4'h3;
  localparam logic [3:0] RCLP_DIV8  = 4'h7;
  localparam logic [3:0] RCLP_DIV16 = 4'hF;
  // clock output select codes
  localparam logic [1:0] RCLP_OUT_F8  = 2'h1;
  localparam logic [1:0] RCLP_OUT_F32 = 2'h2;
  // axi responses
  localparam logic [1:0] RCLP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RCLP_RESP_SLVERR = 2'h2;
  // power states
  typedef enum logic [2:0] {
    RCLP_RUN  = 3'b001,
    RCLP_WAIT = 3'b010,
    RCLP_STOP = 3'b100
  } rclp_pwr_t;
endpackage : rclp_pkg
`default_nettype wire

/* File: test_reset_clock_lowpower_ctrl.sv */
`default_nettype none
module test_reset_clock_lowpower_ctrl import rclp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic        aclk, aresetn, pin_req, reset_pin_n, osc_stable, wait_exec, usb_seen, cr_seen, ram_seen;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, irq_req, irq_enabled;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, core_reset, usb_reset, ram_init;
  logic vector_fetch, ports_float, port_hold, osc_enable, oscillator_output_drive, cpu_clk_en, watchdog_run;
  logic periph_clock_undivided, periph_clock_div_eight, periph_clock_div_thirtytwo, converter_clock;
  logic ext_clock_units_run, clock_output_pin, clock_output_pin_oe;
  int   errors = 0, cmp_count = 0, n_cpu, n_f1, n_f8, n_f32, n_ad, n_out;
  logic [33:0] rq [$];
  logic [3:0]  m [4] = '{RCLP_DIV1, RCLP_DIV2, RCLP_DIV4, RCLP_DIV16};
  rclp_ctrl rclp_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_n,
    .osc_stable, .wait_exec, .irq_req, .irq_enabled, .core_reset, .usb_reset, .ram_init, .vector_fetch,
    .ports_float, .port_hold, .osc_enable, .oscillator_output_drive, .cpu_clk_en, .watchdog_run,
    .periph_clock_undivided, .periph_clock_div_eight, .periph_clock_div_thirtytwo, .converter_clock,
    .ext_clock_units_run, .clock_output_pin, .clock_output_pin_oe);
  rclp_ext_model rclp_ext_model_i (.aclk, .pin_req, .reset_pin_n, .osc_stable);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ==========================================================
  // compare, verdict, bus tasks
  task automatic chk(string nm, logic [33:0] exp, logic [33:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // ready is combinational, so it is judged at the falling edge before the taking edge
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    logic fa, fw, fb;
    logic [1:0] br;
    @(posedge aclk);
    s_axi_awaddr  <= idx << 2;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      fa = s_axi_awvalid & s_axi_awready;
      fw = s_axi_wvalid & s_axi_wready;
      fb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (fa) s_axi_awvalid <= 1'b0;
      if (fw) s_axi_wvalid <= 1'b0;
      if (fb) begin
        s_axi_bready <= 1'b0;
        chk("bresp", RCLP_RESP_OKAY, br);
        return;
      end
    end
    errors++;
  endtask : wr
  task automatic rd(logic [7:0] idx, logic [7:0] d, logic [1:0] rs = RCLP_RESP_OKAY);
    logic fa, fr;
    rq.push_back({rs, 24'h0, d});
    @(posedge aclk);
    s_axi_araddr  <= idx << 2;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      fa = s_axi_arvalid & s_axi_arready;
      fr = s_axi_rvalid;
      @(posedge aclk);
      if (fa) s_axi_arvalid <= 1'b0;
      if (fr) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    errors++;
  endtask : rd
  task automatic ticks(int n);
    logic lp;
    {n_cpu, n_f1, n_f8, n_f32, n_ad, n_out} = '0;
    lp = clock_output_pin;
    repeat (n) begin
      @(negedge aclk);
      n_cpu += cpu_clk_en;
      n_f1  += periph_clock_undivided;
      n_f8  += periph_clock_div_eight;
      n_f32 += periph_clock_div_thirtytwo;
      n_ad  += converter_clock;
      n_out += (clock_output_pin !== lp);
      lp = clock_output_pin;
    end
    @(posedge aclk);
  endtask : ticks
  // ==========================================================
  // watchers
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (usb_reset === 1'b1) usb_seen <= 1'b1;
    if (core_reset === 1'b1) cr_seen <= 1'b1;
    if (ram_init === 1'b1) ram_seen <= 1'b1;
  end
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  // ==========================================================
  // scenarios
  initial begin
    {aresetn, pin_req, wait_exec, irq_req, irq_enabled, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, usb_seen, cr_seen, ram_seen} = '0;
    s_axi_wstrb = 4'h1;
    void'($urandom(12));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(RCLP_IDX_SCC0, RCLP_SCC0_RST);
    rd(RCLP_IDX_SCC1, RCLP_SCC1_RST);
    rd(RCLP_IDX_STAT, 8'h71);
    rd(8'h0F, 8'h00, RCLP_RESP_SLVERR);
    wr(RCLP_IDX_SCC1, 8'h40);
    rd(RCLP_IDX_SCC1, RCLP_SCC1_RST);
    for (int i = 0; i < 100 && osc_stable !== 1'b1; i++) @(posedge aclk);
    wr(RCLP_IDX_PROT, 8'h01);
    wr(RCLP_IDX_SCC0, {6'h0, RCLP_OUT_F8});
    for (int f = 0; f < 4; f++) begin
      wr(RCLP_IDX_SCC1, 8'(f << 6) | 8'h20);
      ticks(40);
      ticks(64);
      chk("cpu ticks", 64 / (m[f] + 1), n_cpu);
      rd(RCLP_IDX_STAT, {m[f], 4'h1});
    end
    chk("f1 f8 f32 fad", {8'd64, 8'd8, 8'd2, 8'd64}, {n_f1[7:0], n_f8[7:0], n_f32[7:0], n_ad[7:0]});
    chk("out f8", {8'd16, 1'b1}, {n_out[7:0], clock_output_pin_oe});
    wr(RCLP_IDX_SCC0, 8'h40 | RCLP_OUT_F32);
    ticks(40);
    ticks(64);
    chk("div8 out f32", {8'd8, 8'd4}, {n_cpu[7:0], n_out[7:0]});
    wr(RCLP_IDX_SCC0, 8'h62);
    ticks(64);
    chk("osc stop", 0, n_cpu + n_f1 + n_f8);
    wr(RCLP_IDX_SCC0, 8'h02);
    for (int ws = 0; ws < 2; ws++) begin
      wr(RCLP_IDX_SCC0, 8'(ws << 2) | 8'h01);
      irq_enabled <= 8'($urandom()) | 8'h01;
      ticks(40);
      wait_exec <= 1'b1;
      @(posedge aclk);
      wait_exec <= 1'b0;
      ticks(4);
      ticks(64);
      chk("wait hold", {1'b1, 1'b0, 1'b1, 8'd0}, {port_hold, watchdog_run, osc_enable, n_cpu[7:0]});
      chk("wait periph", (ws == 1) ? 0 : {8'd8, 8'd16}, {n_f8[7:0], n_out[7:0]});
      rd(RCLP_IDX_STAT, 8'hF2);
      irq_req <= irq_enabled & (~irq_enabled + 8'h01);
      ticks(4);
      irq_req <= 8'h00;
      ticks(40);
      ticks(64);
      chk("wake div", {1'b0, 8'd4}, {port_hold, n_cpu[7:0]});
    end
    irq_enabled <= 8'h01;
    wr(RCLP_IDX_SCC1, 8'hC1);
    irq_enabled <= 8'hFF;
    irq_req     <= 8'h02;
    ticks(64);
    chk("stop", {1'b0, 1'b1, 8'd0}, {osc_enable, ext_clock_units_run, 8'(n_cpu + n_ad + n_out)});
    chk("drive", 1'b1, oscillator_output_drive);
    rd(RCLP_IDX_STAT, 8'hF4);
    rd(RCLP_IDX_SCC0, 8'h45);
    rd(RCLP_IDX_SCC1, 8'hE1);
    irq_req <= 8'h01;
    ticks(24);
    irq_req <= 8'h00;
    rd(RCLP_IDX_STAT, 8'h71);
    wr(RCLP_IDX_PROT, 8'h03);
    {usb_seen, cr_seen, ram_seen} <= 3'b000;
    wr(RCLP_IDX_MODE0, 8'h08);
    ticks(12);
    chk("sw reset", 3'b100, {cr_seen, usb_seen, ram_seen});
    rd(RCLP_IDX_SCC0, RCLP_SCC0_RST);
    rd(RCLP_IDX_STAT, 8'h71);
    pin_req <= 1'b1;
    @(posedge aclk);
    pin_req <= 1'b0;
    ticks(10);
    chk("pin reset", 3'b111, {ports_float, usb_reset, core_reset});
    for (int i = 0; i < 100 && vector_fetch !== 1'b1; i++) @(negedge aclk);
    chk("vector fetch", 2'b10, {vector_fetch, ports_float});
    end_of_test();
  end
endmodule : test_reset_clock_lowpower_ctrl
`default_nettype wire
